// ---- rtl/smux_pkg.sv ----
/*
  Constants for the status output pin multiplexer: register indices,
  field positions, reset values, pin positions and timing counts.
  Assumes a 100 MHz system clock shared by all users of the package.
*/
package smux_pkg;

  // Register indices; byte address is four times the index
  localparam logic [6:0] SMUX_IDX_GENERAL_CONFIG = 7'h00;
  localparam logic [6:0] SMUX_IDX_OUTPUT_STATUS_VALUE = 7'h02;
  localparam logic [6:0] SMUX_IDX_TX_SECTION_CONFIG = 7'h0c;
  localparam logic [6:0] SMUX_IDX_TX_LINE_CONFIG = 7'h0d;
  localparam logic [6:0] SMUX_IDX_RX_LINE_CONFIG = 7'h46;
  localparam logic [6:0] SMUX_IDX_LINK_STATUS = 7'h48;

  localparam logic [7:0] SMUX_REG_RESET = 8'h00;

  // Field positions
  localparam int SMUX_GEN_DEFECT_SEL_BIT = 2;
  localparam int SMUX_RX_LINE_CONFIG_SECT_EN_BIT = 0;
  localparam int SMUX_RX_LINE_CONFIG_LINE_EN_BIT = 1;
  localparam int SMUX_TX_LINE_CONFIG_LINE_EN_BIT = 4;
  localparam int SMUX_TX_SECTION_CONFIG_SECT_EN_BIT = 6;
  localparam int SMUX_STAT_RX_BUSY_BIT = 0;
  localparam int SMUX_STAT_TX_BUSY_BIT = 1;
  localparam int SMUX_STAT_TX_BIT_BIT = 2;
  localparam int SMUX_STAT_TX_SECT_BIT = 3;

  // Status pin positions
  localparam int SMUX_PIN_RX_CLK = 7;
  localparam int SMUX_PIN_RX_DATA = 6;
  localparam int SMUX_PIN_RX_SECT = 5;
  localparam int SMUX_PIN_TX_CLK = 4;
  localparam int SMUX_PIN_TX_SECT = 3;
  localparam int SMUX_PIN_CELL_SLOT = 2;

  // Timing
  localparam int SMUX_CLK_PERIOD_NS = 10;
  localparam int SMUX_DL_CLK_HIGH_NS = 50;
  localparam int SMUX_DL_CLK_LOW_NS = 50;
  localparam int SMUX_CELL_PULSE_NS = 20;
  localparam int SMUX_DL_CLK_HIGH_CYC =
    (SMUX_DL_CLK_HIGH_NS + SMUX_CLK_PERIOD_NS - 1) / SMUX_CLK_PERIOD_NS;
  localparam int SMUX_DL_CLK_LOW_CYC =
    (SMUX_DL_CLK_LOW_NS + SMUX_CLK_PERIOD_NS - 1) / SMUX_CLK_PERIOD_NS;
  localparam int SMUX_CELL_PULSE_CYC =
    (SMUX_CELL_PULSE_NS + SMUX_CLK_PERIOD_NS - 1) / SMUX_CLK_PERIOD_NS;
  localparam int SMUX_CNT_W = 8;

  typedef enum logic [1:0] {
    SMUX_DL_IDLE = 2'b00,
    SMUX_DL_HIGH = 2'b01,
    SMUX_DL_LOW = 2'b10
  } smux_dl_state_type;

endpackage

// ---- rtl/smux_dl_port.sv ----
/*
  One serial data link bit port: on a bit strobe it drives a clock pulse
  with a data bit and channel indication, and samples a serial input at
  the falling edge of the clock it drives.
  Assumes strobes arrive at least HIGH_CYC + LOW_CYC + 1 clock cycles apart (11 by default).
*/
`timescale 1ns/1ns
module smux_dl_port
  import smux_pkg::*;
#(
  parameter int HIGH_CYC = SMUX_DL_CLK_HIGH_CYC,
  parameter int LOW_CYC = SMUX_DL_CLK_LOW_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bit request
  input wire logic bit_stb_i,
  input wire logic bit_i,
  input wire logic sect_i,
  input wire logic ser_i,
  // Serial side
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic sect_o,
  output logic busy_o,
  // Sampled bit
  output logic sample_o,
  output logic sample_stb_o
);

  localparam logic [SMUX_CNT_W-1:0] HIGH_LAST =
    SMUX_CNT_W'(HIGH_CYC - 1);
  localparam logic [SMUX_CNT_W-1:0] LOW_LAST = SMUX_CNT_W'(LOW_CYC - 1);
  localparam logic [SMUX_CNT_W-1:0] CNT_ZERO = '0;

  smux_dl_state_type state_q;
  logic [SMUX_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SMUX_DL_IDLE;
      cnt_q <= CNT_ZERO;
      ser_clk_o <= 1'b0;
      ser_data_o <= 1'b0;
      sect_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      case (state_q)
        SMUX_DL_IDLE: begin
          // Strobes while busy are dropped, so the source must pace itself
          if (bit_stb_i) begin
            state_q <= SMUX_DL_HIGH;
            cnt_q <= HIGH_LAST;
            ser_clk_o <= 1'b1;
            ser_data_o <= bit_i;
            sect_o <= sect_i;
            busy_o <= 1'b1;
          end
        end
        SMUX_DL_HIGH: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= SMUX_DL_LOW;
            cnt_q <= LOW_LAST;
            ser_clk_o <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SMUX_DL_LOW: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= SMUX_DL_IDLE;
            busy_o <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= SMUX_DL_IDLE;
          ser_clk_o <= 1'b0;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Sample at the falling edge of the driven clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o <= 1'b0;
      sample_stb_o <= 1'b0;
    end else begin
      sample_stb_o <= 1'b0;
      if (state_q == SMUX_DL_HIGH && cnt_q == CNT_ZERO) begin
        sample_o <= ser_i;
        sample_stb_o <= 1'b1;
      end
    end
  end

endmodule

// ---- rtl/smux_slot_pulse.sv ----
/*
  Cell slot pulse stretcher: each slot start gives a pulse of fixed width.
  Assumes slot starts are already in the system clock domain.
*/
`timescale 1ns/1ns
module smux_slot_pulse
  import smux_pkg::*;
#(
  parameter int PULSE_CYC = SMUX_CELL_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slot start and pulse
  input wire logic start_i,
  output logic pulse_o
);

  localparam logic [SMUX_CNT_W-1:0] PULSE_LAST =
    SMUX_CNT_W'(PULSE_CYC - 1);
  localparam logic [SMUX_CNT_W-1:0] CNT_ZERO = '0;

  logic [SMUX_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= CNT_ZERO;
      pulse_o <= 1'b0;
    end else if (start_i) begin
      // A new slot restarts the pulse rather than merging into it
      cnt_q <= PULSE_LAST;
      pulse_o <= 1'b1;
    end else if (cnt_q != CNT_ZERO) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule

// ---- rtl/smux_top.sv ----
/*
  Status output pin multiplexer with its Wishbone register slave.
  Each status pin shows a software bit or a defect flag; on the WAN
  variant the upper pins may carry receive and transmit data link timing
  and the cell slot strobe instead.
  Assumes defect flags, link bit strobes and slot starts are synchronous
  to clk_i, and a classic Wishbone master with 32-bit data.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
module smux_top
  import smux_pkg::*;
#(
  parameter bit WAN_VARIANT = 1'b1,
  parameter int ADR_W = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Defect flags
  input wire logic los_i,
  input wire logic oof_i,
  input wire logic lop_i,
  input wire logic ais_l_i,
  input wire logic rdi_l_i,
  input wire logic ais_p_i,
  input wire logic rdi_p_i,
  input wire logic locd_i,
  // Receive link bits from overhead extraction
  input wire logic rx_dl_bit_stb_i,
  input wire logic rx_dl_bit_i,
  input wire logic rx_dl_sect_i,
  // Transmit link bit requests from overhead insertion
  input wire logic tx_dl_req_i,
  input wire logic tx_dl_sect_i,
  output logic tx_dl_bit_o,
  output logic tx_dl_bit_stb_o,
  // Transmit cell slot start
  input wire logic cell_slot_start_i,
  // Pins
  input wire logic tx_link_serial_in_i,
  output logic [7:0] status_pins_o
);

  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

  logic [7:0] general_config_q;
  logic [7:0] output_status_value_q;
  logic [7:0] tx_section_config_q;
  logic [7:0] tx_line_config_q;
  logic [7:0] rx_line_config_q;
  logic [7:0] link_status_d;
  logic [7:0] status_pins_d;
  logic [7:0] defect_vec;
  logic [6:0] word_idx;
  logic wb_req;
  logic wb_wr;
  logic rx_sel;
  logic tx_sel;
  logic rx_ch_en;
  logic tx_ch_en;
  logic rx_clk;
  logic rx_data;
  logic rx_sect;
  logic rx_busy;
  logic tx_clk;
  logic tx_sect;
  logic tx_busy;
  logic tx_sample;
  logic tx_sample_stb;
  logic slot_pulse;
  logic tx_serial;

  function automatic logic reg_hit(input logic [6:0] idx,
                                   input logic [6:0] reg_idx);
    reg_hit = (idx == reg_idx);
  endfunction

  assign word_idx = wb_adr_i[8:2];
  assign wb_req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0] & wb_ack_o;

  // Bus answer: one wait cycle, then ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= DAT_ZERO;
    end else if (wb_req & ~wb_ack_o) begin
      wb_dat_o <= DAT_ZERO;
      if (reg_hit(word_idx, SMUX_IDX_GENERAL_CONFIG)) begin
        wb_dat_o[7:0] <= general_config_q;
      end else if (reg_hit(word_idx, SMUX_IDX_OUTPUT_STATUS_VALUE)) begin
        wb_dat_o[7:0] <= output_status_value_q;
      end else if (reg_hit(word_idx, SMUX_IDX_TX_SECTION_CONFIG)) begin
        wb_dat_o[7:0] <= tx_section_config_q;
      end else if (reg_hit(word_idx, SMUX_IDX_TX_LINE_CONFIG)) begin
        wb_dat_o[7:0] <= tx_line_config_q;
      end else if (reg_hit(word_idx, SMUX_IDX_RX_LINE_CONFIG)) begin
        wb_dat_o[7:0] <= rx_line_config_q;
      end else if (reg_hit(word_idx, SMUX_IDX_LINK_STATUS)) begin
        wb_dat_o[7:0] <= link_status_d;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_config_q <= SMUX_REG_RESET;
      output_status_value_q <= SMUX_REG_RESET;
      tx_section_config_q <= SMUX_REG_RESET;
      tx_line_config_q <= SMUX_REG_RESET;
      rx_line_config_q <= SMUX_REG_RESET;
    end else if (wb_wr) begin
      if (reg_hit(word_idx, SMUX_IDX_GENERAL_CONFIG)) begin
        general_config_q <= wb_dat_i[7:0];
      end
      if (reg_hit(word_idx, SMUX_IDX_OUTPUT_STATUS_VALUE)) begin
        output_status_value_q <= wb_dat_i[7:0];
      end
      if (reg_hit(word_idx, SMUX_IDX_TX_SECTION_CONFIG)) begin
        tx_section_config_q <= wb_dat_i[7:0];
      end
      if (reg_hit(word_idx, SMUX_IDX_TX_LINE_CONFIG)) begin
        tx_line_config_q <= wb_dat_i[7:0];
      end
      if (reg_hit(word_idx, SMUX_IDX_RX_LINE_CONFIG)) begin
        rx_line_config_q <= wb_dat_i[7:0];
      end
    end
  end

  always_comb begin
    link_status_d = SMUX_REG_RESET;
    link_status_d[SMUX_STAT_RX_BUSY_BIT] = rx_busy;
    link_status_d[SMUX_STAT_TX_BUSY_BIT] = tx_busy;
    link_status_d[SMUX_STAT_TX_BIT_BIT] = tx_dl_bit_o;
    link_status_d[SMUX_STAT_TX_SECT_BIT] = tx_sect;
  end

  // Link selection exists only on the WAN variant
  assign rx_sel = WAN_VARIANT &
    (rx_line_config_q[SMUX_RX_LINE_CONFIG_SECT_EN_BIT] |
     rx_line_config_q[SMUX_RX_LINE_CONFIG_LINE_EN_BIT]);
  assign tx_sel = WAN_VARIANT &
    (tx_line_config_q[SMUX_TX_LINE_CONFIG_LINE_EN_BIT] |
     tx_section_config_q[SMUX_TX_SECTION_CONFIG_SECT_EN_BIT]);
  // Each channel bit lets only its own octets through
  assign rx_ch_en = rx_dl_sect_i ?
    rx_line_config_q[SMUX_RX_LINE_CONFIG_SECT_EN_BIT] :
    rx_line_config_q[SMUX_RX_LINE_CONFIG_LINE_EN_BIT];
  assign tx_ch_en = tx_dl_sect_i ?
    tx_section_config_q[SMUX_TX_SECTION_CONFIG_SECT_EN_BIT] :
    tx_line_config_q[SMUX_TX_LINE_CONFIG_LINE_EN_BIT];
  // A grounded LAN input is ignored anyway
  assign tx_serial = WAN_VARIANT & tx_link_serial_in_i;

  smux_dl_port u_rx_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bit_stb_i(rx_dl_bit_stb_i & rx_sel & rx_ch_en),
    .bit_i(rx_dl_bit_i),
    .sect_i(rx_dl_sect_i),
    .ser_i(1'b0),
    .ser_clk_o(rx_clk),
    .ser_data_o(rx_data),
    .sect_o(rx_sect),
    .busy_o(rx_busy),
    .sample_o(),
    .sample_stb_o()
  );

  smux_dl_port u_tx_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bit_stb_i(tx_dl_req_i & tx_sel & tx_ch_en),
    .bit_i(1'b0),
    .sect_i(tx_dl_sect_i),
    .ser_i(tx_serial),
    .ser_clk_o(tx_clk),
    .ser_data_o(),
    .sect_o(tx_sect),
    .busy_o(tx_busy),
    .sample_o(tx_sample),
    .sample_stb_o(tx_sample_stb)
  );

  smux_slot_pulse u_slot (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cell_slot_start_i & tx_sel),
    .pulse_o(slot_pulse)
  );

  // Sampled bits go on to overhead insertion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_dl_bit_o <= 1'b0;
      tx_dl_bit_stb_o <= 1'b0;
    end else begin
      tx_dl_bit_stb_o <= tx_sample_stb;
      if (tx_sample_stb) begin
        tx_dl_bit_o <= tx_sample;
      end
    end
  end

  assign defect_vec = {los_i, oof_i, lop_i, ais_l_i,
                       rdi_l_i, ais_p_i, rdi_p_i, locd_i};

  always_comb begin
    status_pins_d = general_config_q[SMUX_GEN_DEFECT_SEL_BIT] ?
      defect_vec : output_status_value_q;
    if (rx_sel) begin
      status_pins_d[SMUX_PIN_RX_CLK] = rx_clk;
      status_pins_d[SMUX_PIN_RX_DATA] = rx_data;
      status_pins_d[SMUX_PIN_RX_SECT] = rx_sect;
    end
    if (tx_sel) begin
      status_pins_d[SMUX_PIN_TX_CLK] = tx_clk;
      status_pins_d[SMUX_PIN_TX_SECT] = tx_sect;
      status_pins_d[SMUX_PIN_CELL_SLOT] = slot_pulse;
    end
  end

  // One register stage keeps the pins glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_pins_o <= SMUX_REG_RESET;
    end else begin
      status_pins_o <= status_pins_d;
    end
  end

endmodule

// ---- testbench/smux_checker.sv ----
/*
  Assertions on the status pin multiplexer ports.
  Assumes binding to smux_top and one clock domain.
*/
`timescale 1ns/1ns
module smux_checker
  import smux_pkg::*;
#(
  parameter int ADR_W = 9
) (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic los_i, oof_i, lop_i, ais_l_i, rdi_l_i, ais_p_i,
  input wire logic rdi_p_i, locd_i, rx_dl_bit_i, rx_dl_sect_i,
  input wire logic tx_dl_sect_i, tx_dl_bit_o, tx_dl_bit_stb_o,
  input wire logic cell_slot_start_i, tx_link_serial_in_i,
  input wire logic [7:0] status_pins_o
);
  // Shadow of the registers, updated where the slave takes a write
  logic [7:0] gen_q, out_q, txs_q, txl_q, rxl_q;
  logic rx_sel, tx_sel;
  assign rx_sel = rxl_q[0] | rxl_q[1];
  assign tx_sel = txl_q[4] | txs_q[6];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {gen_q, out_q, txs_q, txl_q, rxl_q} <= '0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                 wb_sel_i[0]) begin
      case (wb_adr_i[8:2])
        SMUX_IDX_GENERAL_CONFIG: gen_q <= wb_dat_i[7:0];
        SMUX_IDX_OUTPUT_STATUS_VALUE: out_q <= wb_dat_i[7:0];
        SMUX_IDX_TX_SECTION_CONFIG: txs_q <= wb_dat_i[7:0];
        SMUX_IDX_TX_LINE_CONFIG: txl_q <= wb_dat_i[7:0];
        SMUX_IDX_RX_LINE_CONFIG: rxl_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_soft_bits: assert property (
    !$past(gen_q[2] | rx_sel | tx_sel) |-> status_pins_o == $past(out_q))
    else $error("pins differ from soft bits");
  a_defect_order: assert property (
    $past(gen_q[2] & !rx_sel & !tx_sel) |-> status_pins_o == $past({los_i,
    oof_i, lop_i, ais_l_i, rdi_l_i, ais_p_i, rdi_p_i, locd_i}))
    else $error("pins differ from defect flags");
  a_rx_clk_width: assert property (
    rx_sel && $rose(status_pins_o[7]) |->
    status_pins_o[7][*5] ##1 !status_pins_o[7])
    else $error("rx link clock width wrong");
  a_rx_bit_sect: assert property (
    rx_sel && $rose(status_pins_o[7]) |->
    status_pins_o[6:5] == $past({rx_dl_bit_i, rx_dl_sect_i}, 2))
    else $error("rx link data or section wrong");
  a_tx_clk_width: assert property (
    tx_sel && $rose(status_pins_o[4]) |->
    status_pins_o[4][*5] ##1 !status_pins_o[4])
    else $error("tx link clock width wrong");
  a_tx_sect_pin: assert property (
    tx_sel && $rose(status_pins_o[4]) |->
    status_pins_o[3] == $past(tx_dl_sect_i, 2))
    else $error("tx link section wrong");
  a_slot_pulse: assert property (
    tx_sel && cell_slot_start_i |-> ##2 status_pins_o[2][*2])
    else $error("cell slot pulse missing");
  a_tx_sample: assert property (
    tx_dl_bit_stb_o |-> tx_dl_bit_o == $past(tx_link_serial_in_i, 2))
    else $error("tx link bit sampled at wrong time");
endmodule
bind smux_top smux_checker #(.ADR_W(ADR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .los_i(los_i), .oof_i(oof_i),
  .lop_i(lop_i), .ais_l_i(ais_l_i), .rdi_l_i(rdi_l_i), .ais_p_i(ais_p_i),
  .rdi_p_i(rdi_p_i), .locd_i(locd_i), .rx_dl_bit_i(rx_dl_bit_i),
  .rx_dl_sect_i(rx_dl_sect_i), .tx_dl_sect_i(tx_dl_sect_i),
  .tx_dl_bit_o(tx_dl_bit_o), .tx_dl_bit_stb_o(tx_dl_bit_stb_o),
  .cell_slot_start_i(cell_slot_start_i),
  .tx_link_serial_in_i(tx_link_serial_in_i),
  .status_pins_o(status_pins_o));

// ---- testbench/smux_link_model.sv ----
/*
  External transmit link source: shifts out a fixed bit pattern.
  Assumes the link clock arrives on a status pin, synchronous to clk_i.
*/
`timescale 1ns/1ns
module smux_link_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link side
  input wire logic link_clk_i,
  output logic ser_o,
  output logic last_o
);
  logic prev_q;
  logic [7:0] pat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      pat_q <= 8'hb4;
      ser_o <= 1'b0;
      last_o <= 1'b0;
    end else begin
      prev_q <= link_clk_i;
      if (link_clk_i && !prev_q) begin
        ser_o <= pat_q[7];
        last_o <= pat_q[7];
        pat_q <= {pat_q[6:0], pat_q[7]};
      end else if (!link_clk_i && prev_q) begin
        // Hold time over: show a wrong value so late sampling is caught
        ser_o <= ~last_o;
      end
    end
  end
endmodule

// ---- testbench/testbench.sv ----
/*
  Register, defect, link and cell slot tests of smux_top.
  Assumes the link model on pin 4 and a classic Wishbone master here.
*/
`timescale 1ns/1ns
module testbench;
  import smux_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ser, last;
  logic rs = 0, rb = 0, rc = 0, tq = 0, tc = 0, cs = 0, tbit, tstb;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [7:0] dft = 8'h00, pins;
  logic [8:0] ra [5] = '{9'h000, 9'h008, 9'h030, 9'h034, 9'h118};
  int errors = 0, checks = 0, cyc_n = 0, i, n;
  smux_top #(.WAN_VARIANT(1'b1), .ADR_W(9)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .los_i(dft[7]), .oof_i(dft[6]),
    .lop_i(dft[5]), .ais_l_i(dft[4]), .rdi_l_i(dft[3]), .ais_p_i(dft[2]),
    .rdi_p_i(dft[1]), .locd_i(dft[0]), .rx_dl_bit_stb_i(rs),
    .rx_dl_bit_i(rb), .rx_dl_sect_i(rc), .tx_dl_req_i(tq),
    .tx_dl_sect_i(tc), .tx_dl_bit_o(tbit), .tx_dl_bit_stb_o(tstb),
    .cell_slot_start_i(cs), .tx_link_serial_in_i(ser),
    .status_pins_o(pins));
  smux_link_model u_mdl (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(pins[4]), .ser_o(ser), .last_o(last));
  initial forever #5 clk_i = ~clk_i;
  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task wait_pin(input int b);
    do begin
      @(posedge clk_i);
      #1;
    end while (pins[b] !== 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wb(0, ra[i], 8'h00);
      chk("reset value", 8'h00, q);
      wb(1, ra[i], 8'h81);
      wb(0, ra[i], 8'h00);
      chk("read back", 8'h81, q);
      wb(1, ra[i], 8'h00);
    end
    wb(1, 9'h1fc, 8'hff);
    wb(0, 9'h1fc, 8'h00);
    chk("unmapped", 8'h00, q);
    sel <= 4'h0;
    wb(1, 9'h008, 8'hff);
    sel <= 4'h1;
    wb(0, 9'h008, 8'h00);
    chk("lane off write", 8'h00, q);
    $display("register test done");
    wb(1, 9'h008, 8'ha5);
    settle();
    chk("soft pins", 8'ha5, pins);
    wb(1, 9'h000, 8'h04);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_i);
      dft <= 8'h01 << i;
      settle();
      chk("defect pins", 8'h01 << i, pins);
    end
    dft <= 8'h00;
    wb(1, 9'h000, 8'h00);
    wb(1, 9'h008, 8'h00);
    $display("pin source test done");
    wb(1, 9'h118, 8'h03);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i);
      rs <= 1'b1;
      rb <= i[0];
      rc <= i[1];
      @(posedge clk_i);
      rs <= 1'b0;
      wait_pin(7);
      chk("rx data pin", i[0], pins[6]);
      chk("rx sect pin", i[1], pins[5]);
      repeat (12) @(posedge clk_i);
    end
    wb(1, 9'h118, 8'h00);
    $display("rx link test done");
    wb(1, 9'h034, 8'h10);
    wb(1, 9'h030, 8'h40);
    for (i = 0; i < 6; i++) begin
      @(posedge clk_i);
      tq <= 1'b1;
      tc <= i[0];
      @(posedge clk_i);
      tq <= 1'b0;
      wait_pin(4);
      chk("tx sect pin", i[0], pins[3]);
      do begin
        @(posedge clk_i);
        #1;
      end while (tstb !== 1'b1);
      chk("tx bit", last, tbit);
      repeat (6) @(posedge clk_i);
    end
    // Link status: idle, last bit and last section (odd pass, so high)
    wb(0, 9'h120, 8'h00);
    chk("link status", {28'h000_0000, 1'b1, last, 2'b00}, q);
    $display("tx link test done");
    // Section enable alone must still select the slot strobe
    wb(1, 9'h034, 8'h00);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i);
      cs <= 1'b1;
      @(posedge clk_i);
      cs <= 1'b0;
      n = 0;
      repeat (8) begin
        @(posedge clk_i);
        #1;
        if (pins[2] === 1'b1) n++;
      end
      chk("slot pulse cycles", 2, n);
    end
    $display("cell slot test done");
    give_verdict();
  end
endmodule
